// ---- common/irq_flags_pkg.sv ----
package irq_flags_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_MASK = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_RCLR_STATUS = 8'h08;
   localparam logic [7:0] OFS_MODE = 8'h0C;
   localparam logic [7:0] OFS_CALC_MODE = 8'h10;
   // field positions
   localparam int BIT_SAG_A = 3;
   localparam int BIT_ZXTO_A = 6;
   localparam int BIT_ZX_A = 9;
   localparam int BIT_ENERGY_DONE = 12;
   localparam int BIT_RESET_DONE = 13;
   localparam int BIT_VOLT_PEAK = 14;
   localparam int BIT_CURR_PEAK = 15;
   localparam int BIT_WAVE_READY = 16;
   localparam int BIT_ACT_SIGN = 17;
   localparam int BIT_REACT_SIGN = 18;
   localparam int BIT_ORDER_ERR = 19;
   localparam int BIT_SOFT_RESET = 6;
   localparam int FLAG_LO = 3;
   localparam int FLAG_W = 20;
   // reset values
   localparam logic [19:0] STATUS_RST = 20'h02000;
   localparam logic [19:0] MASK_RST = 20'h00000;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [2:0] PHASE_SEL_RST = 3'h7;
   // soft reset duration
   localparam int CLK_MHZ = 250;
   localparam int SOFT_RESET_NS = 166000;
   localparam int SOFT_RESET_CYC = (SOFT_RESET_NS * CLK_MHZ + 999) / 1000;
endpackage

// ---- src/meter_interrupt_status_flags.sv ----
// Overview of operation
// R1: sag events set bits 3 to 5
// R2: missing crossings set bits 6 to 8
// R3: rising crossings set bits 9 to 11
// R4: line-cycle energy done sets bit 12
// R5: soft reset sets bit 13 after 166us
// R6: registers return to defaults on the same edge as done flag
// R7: reset-done defaults one, clears on clearing read
// R8: voltage peak over threshold sets bit 14
// R9: current peak over threshold sets bit 15
// R10: new waveform sample sets bit 16
// R11: selected active power sign flip sets bit 17
// R12: selected reactive power sign flip sets bit 18
// R13: A then B crossing sets bit 19
// R14: flags sticky until clearing status read
// R15: irq low when flag set and unmasked
// R16: clearing status read releases irq
// R17: plain status read changes nothing
//
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module meter_interrupt_status_flags #(
   parameter int SOFT_RESET_CYCLES = irq_flags_pkg::SOFT_RESET_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // event strobes from the detectors, one cycle each
   input wire logic [2:0] sag_evt,
   input wire logic [2:0] zx_timeout_evt,
   input wire logic [2:0] zx_rise_evt,
   input wire logic line_cycle_evt,
   input wire logic volt_peak_evt,
   input wire logic curr_peak_evt,
   input wire logic wave_sample_evt,
   input wire logic [2:0] active_sign_evt,
   input wire logic [2:0] reactive_sign_evt,
   // interrupt and soft reset state
   output logic irq_n,
   output logic soft_reset_busy,
   output logic [2:0] phase_include_select
);
   typedef struct packed {
      logic [19:0] status;
      logic [19:0] mask;
      logic [7:0] mode_reg;
      logic [2:0] phase_sel;
      logic busy;
      logic [31:0] rst_cnt;
      logic [1:0] zx_last;
      logic ph_write;
      logic ph_read;
      logic [7:0] ph_addr;
      logic [31:0] rdata;
      logic irq_n;
   } state_s;

   state_s cur_ff, nxt_ff;
   logic [19:0] set_vec;
   logic [19:0] flags_now;
   logic seq_err;

   assign hrdata = cur_ff.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign irq_n = cur_ff.irq_n;
   assign soft_reset_busy = cur_ff.busy;
   assign phase_include_select = cur_ff.phase_sel;

   always_comb begin
      nxt_ff = cur_ff;
      set_vec = '0;
      seq_err = 1'b0;
      // phase order tracking: a B crossing right after A is an order error
      if (zx_rise_evt[0]) begin
         nxt_ff.zx_last = 2'h1;
      end else if (zx_rise_evt[1]) begin
         seq_err = (cur_ff.zx_last == 2'h1); // R13
         nxt_ff.zx_last = 2'h2;
      end else if (zx_rise_evt[2]) begin
         nxt_ff.zx_last = 2'h3;
      end
      if (!cur_ff.busy) begin
         set_vec[irq_flags_pkg::BIT_SAG_A +: 3] = sag_evt; // R1
         set_vec[irq_flags_pkg::BIT_ZXTO_A +: 3] = zx_timeout_evt; // R2
         set_vec[irq_flags_pkg::BIT_ZX_A +: 3] = zx_rise_evt; // R3
         set_vec[irq_flags_pkg::BIT_ENERGY_DONE] = line_cycle_evt; // R4
         set_vec[irq_flags_pkg::BIT_VOLT_PEAK] = volt_peak_evt; // R8
         set_vec[irq_flags_pkg::BIT_CURR_PEAK] = curr_peak_evt; // R9
         set_vec[irq_flags_pkg::BIT_WAVE_READY] = wave_sample_evt; // R10
         set_vec[irq_flags_pkg::BIT_ACT_SIGN] = |(active_sign_evt & cur_ff.phase_sel); // R11
         set_vec[irq_flags_pkg::BIT_REACT_SIGN] = |(reactive_sign_evt & cur_ff.phase_sel); // R12
         set_vec[irq_flags_pkg::BIT_ORDER_ERR] = seq_err; // R13
      end
      // data phase of the previous address phase
      if (cur_ff.ph_write) begin
         unique case (cur_ff.ph_addr)
            irq_flags_pkg::OFS_MASK: nxt_ff.mask = hwdata[19:0];
            irq_flags_pkg::OFS_CALC_MODE: nxt_ff.phase_sel = hwdata[2:0];
            irq_flags_pkg::OFS_MODE: begin
               nxt_ff.mode_reg = hwdata[7:0];
               if (hwdata[irq_flags_pkg::BIT_SOFT_RESET] && !cur_ff.busy) begin
                  nxt_ff.busy = 1'b1; // R5
                  nxt_ff.rst_cnt = 32'h0;
               end
            end
            default: ;
         endcase
      end
      // clearing read; events of the same cycle survive
      flags_now = cur_ff.status;
      if (cur_ff.ph_read && cur_ff.ph_addr == irq_flags_pkg::OFS_RCLR_STATUS) begin
         flags_now = 20'h0; // R7 R14 R16
      end
      nxt_ff.status = flags_now | set_vec; // R14
      if (cur_ff.busy) begin
         if (cur_ff.rst_cnt >= 32'(SOFT_RESET_CYCLES - 1)) begin
            nxt_ff.busy = 1'b0;
            nxt_ff.mask = irq_flags_pkg::MASK_RST; // R6
            nxt_ff.mode_reg = irq_flags_pkg::MODE_RST;
            nxt_ff.phase_sel = irq_flags_pkg::PHASE_SEL_RST;
            nxt_ff.zx_last = 2'h0;
            nxt_ff.status = irq_flags_pkg::STATUS_RST; // R5 R6
         end else begin
            nxt_ff.rst_cnt = cur_ff.rst_cnt + 32'h1;
         end
      end
      nxt_ff.irq_n = ~|(nxt_ff.status & nxt_ff.mask & 20'hFFFF8); // R15
      nxt_ff.ph_write = 1'b0;
      nxt_ff.ph_read = 1'b0;
      if (hsel && hready && htrans[1]) begin
         nxt_ff.ph_write = hwrite;
         nxt_ff.ph_read = !hwrite;
         nxt_ff.ph_addr = haddr;
         unique case (haddr)
            irq_flags_pkg::OFS_MASK: nxt_ff.rdata = {12'h0, cur_ff.mask};
            irq_flags_pkg::OFS_STATUS: nxt_ff.rdata = {12'h0, cur_ff.status}; // R17
            irq_flags_pkg::OFS_RCLR_STATUS: nxt_ff.rdata = {12'h0, cur_ff.status};
            irq_flags_pkg::OFS_MODE: nxt_ff.rdata = {24'h0, cur_ff.mode_reg};
            irq_flags_pkg::OFS_CALC_MODE: nxt_ff.rdata = {29'h0, cur_ff.phase_sel};
            default: nxt_ff.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cur_ff <= '{status: irq_flags_pkg::STATUS_RST, mask: irq_flags_pkg::MASK_RST,
                     mode_reg: irq_flags_pkg::MODE_RST, phase_sel: irq_flags_pkg::PHASE_SEL_RST,
                     busy: 1'b0, rst_cnt: 32'h0, zx_last: 2'h0, ph_write: 1'b0,
                     ph_read: 1'b0, ph_addr: 8'h0, rdata: 32'h0, irq_n: 1'b1};
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   a_irq_follows_flags: assert property (@(posedge clk) disable iff (!arst_n)
      1'b1 |=> (irq_n == ~|($past(nxt_ff.status) & $past(nxt_ff.mask) & 20'hFFFF8))) // R15
      else $error("irq does not follow unmasked flags");
   a_sag_sets: assert property (@(posedge clk) disable iff (!arst_n)
      (sag_evt[0] && !cur_ff.busy) |=> cur_ff.status[3]) // R1
      else $error("sag a flag not set");
   a_timeout_sets: assert property (@(posedge clk) disable iff (!arst_n)
      (zx_timeout_evt[2] && !cur_ff.busy) |=> cur_ff.status[8]) // R2
      else $error("timeout c flag not set");
   a_rise_sets: assert property (@(posedge clk) disable iff (!arst_n)
      (zx_rise_evt[1] && !cur_ff.busy) |=> cur_ff.status[10]) // R3
      else $error("crossing b flag not set");
   a_energy_sets: assert property (@(posedge clk) disable iff (!arst_n)
      (line_cycle_evt && !cur_ff.busy) |=> cur_ff.status[12]) // R4
      else $error("energy flag not set");
   a_peak_sets: assert property (@(posedge clk) disable iff (!arst_n)
      (volt_peak_evt && curr_peak_evt && !cur_ff.busy) |=> (cur_ff.status[15:14] == 2'h3)) // R8 R9
      else $error("peak flags not set");
   a_wave_sets: assert property (@(posedge clk) disable iff (!arst_n)
      (wave_sample_evt && !cur_ff.busy) |=> cur_ff.status[16]) // R10
      else $error("waveform flag not set");
   a_sign_sets: assert property (@(posedge clk) disable iff (!arst_n)
      (!cur_ff.busy && |(active_sign_evt & cur_ff.phase_sel)) |=> cur_ff.status[17]) // R11
      else $error("active sign flag not set");
   a_vsign_sets: assert property (@(posedge clk) disable iff (!arst_n)
      (!cur_ff.busy && |(reactive_sign_evt & cur_ff.phase_sel)) |=> cur_ff.status[18]) // R12
      else $error("reactive sign flag not set");
   a_seq_err: assert property (@(posedge clk) disable iff (!arst_n)
      (!cur_ff.busy && zx_rise_evt == 3'h2 && cur_ff.zx_last == 2'h1) |=> cur_ff.status[19]) // R13
      else $error("sequence error not flagged");
   a_flags_sticky: assert property (@(posedge clk) disable iff (!arst_n)
      (!(cur_ff.ph_read && cur_ff.ph_addr == irq_flags_pkg::OFS_RCLR_STATUS) && !cur_ff.busy)
      |=> ((cur_ff.status & $past(cur_ff.status)) == $past(cur_ff.status))) // R14 R17
      else $error("flag dropped without clearing read");
   a_reset_done: assert property (@(posedge clk) disable iff (!arst_n)
      (cur_ff.busy && cur_ff.rst_cnt == 32'(SOFT_RESET_CYCLES - 1))
      |=> (!cur_ff.busy && cur_ff.status == irq_flags_pkg::STATUS_RST && cur_ff.mask == 20'h0)) // R5 R6
      else $error("soft reset did not finish with defaults");
   a_clear_read: assert property (@(posedge clk) disable iff (!arst_n)
      (cur_ff.ph_read && cur_ff.ph_addr == irq_flags_pkg::OFS_RCLR_STATUS && !cur_ff.busy
       && set_vec == 20'h0) |=> (cur_ff.status == 20'h0 && irq_n)) // R7 R16
      else $error("clearing read did not clear");

   // per-phase event checks, one copy per phase
   for (genvar g = 0; g < 3; g++) begin : g_phase
      a_sag_phase: assert property (@(posedge clk) disable iff (!arst_n)
         (sag_evt[g] && !cur_ff.busy) |=> cur_ff.status[irq_flags_pkg::BIT_SAG_A + g]) // R1
         else $error("sag flag of a phase not set");
      a_timeout_phase: assert property (@(posedge clk) disable iff (!arst_n)
         (zx_timeout_evt[g] && !cur_ff.busy) |=> cur_ff.status[irq_flags_pkg::BIT_ZXTO_A + g]) // R2
         else $error("timeout flag of a phase not set");
      a_rise_phase: assert property (@(posedge clk) disable iff (!arst_n)
         (zx_rise_evt[g] && !cur_ff.busy) |=> cur_ff.status[irq_flags_pkg::BIT_ZX_A + g]) // R3
         else $error("crossing flag of a phase not set");
      a_act_phase: assert property (@(posedge clk) disable iff (!arst_n)
         (!cur_ff.busy && active_sign_evt[g] && cur_ff.phase_sel[g])
         |=> cur_ff.status[irq_flags_pkg::BIT_ACT_SIGN]) // R11
         else $error("selected active sign flip not flagged");
      a_react_phase: assert property (@(posedge clk) disable iff (!arst_n)
         (!cur_ff.busy && reactive_sign_evt[g] && cur_ff.phase_sel[g])
         |=> cur_ff.status[irq_flags_pkg::BIT_REACT_SIGN]) // R12
         else $error("selected reactive sign flip not flagged");
   end

   // interrupt level against the flags it stands for
   a_irq_low_set: assert property (@(posedge clk) disable iff (!arst_n)
      (|(cur_ff.status & cur_ff.mask & 20'hFFFF8)) |-> !irq_n) // R15
      else $error("irq not low with an unmasked flag");
   a_irq_high_clear: assert property (@(posedge clk) disable iff (!arst_n)
      !(|(cur_ff.status & cur_ff.mask & 20'hFFFF8)) |-> irq_n) // R15
      else $error("irq low with no unmasked flag");
   a_volt_peak: assert property (@(posedge clk) disable iff (!arst_n)
      (volt_peak_evt && !cur_ff.busy) |=> cur_ff.status[irq_flags_pkg::BIT_VOLT_PEAK]) // R8
      else $error("voltage peak flag not set");
   a_curr_peak: assert property (@(posedge clk) disable iff (!arst_n)
      (curr_peak_evt && !cur_ff.busy) |=> cur_ff.status[irq_flags_pkg::BIT_CURR_PEAK]) // R9
      else $error("current peak flag not set");
   a_low_bits: assert property (@(posedge clk) disable iff (!arst_n)
      cur_ff.status[2:0] == 3'h0) // R14
      else $error("flag below bit three set");
   a_plain_read_irq: assert property (@(posedge clk) disable iff (!arst_n)
      (cur_ff.ph_read && cur_ff.ph_addr == irq_flags_pkg::OFS_STATUS && !cur_ff.busy && !irq_n)
      |=> !irq_n) // R17
      else $error("plain status read released irq");
   a_plain_read_data: assert property (@(posedge clk) disable iff (!arst_n)
      (hsel && hready && htrans[1] && !hwrite && haddr == irq_flags_pkg::OFS_STATUS)
      |=> (hrdata == {12'h0, $past(cur_ff.status)})) // R17
      else $error("status read returned wrong flags");
   a_clear_read_data: assert property (@(posedge clk) disable iff (!arst_n)
      (hsel && hready && htrans[1] && !hwrite && haddr == irq_flags_pkg::OFS_RCLR_STATUS)
      |=> (hrdata == {12'h0, $past(cur_ff.status)})) // R16
      else $error("clearing read returned wrong flags");

   // soft reset sequence
   a_reset_start: assert property (@(posedge clk) disable iff (!arst_n)
      (cur_ff.ph_write && cur_ff.ph_addr == irq_flags_pkg::OFS_MODE
       && hwdata[irq_flags_pkg::BIT_SOFT_RESET] && !cur_ff.busy) |=> soft_reset_busy) // R5
      else $error("soft reset did not start");
   a_reset_span: assert property (@(posedge clk) disable iff (!arst_n)
      cur_ff.busy |-> (cur_ff.rst_cnt < 32'(SOFT_RESET_CYCLES))) // R5
      else $error("soft reset counter overran");
   a_busy_quiet: assert property (@(posedge clk) disable iff (!arst_n)
      (cur_ff.busy && cur_ff.rst_cnt < 32'(SOFT_RESET_CYCLES - 1)
       && !(cur_ff.ph_read && cur_ff.ph_addr == irq_flags_pkg::OFS_RCLR_STATUS))
      |=> (cur_ff.status == $past(cur_ff.status))) // R6
      else $error("flag changed during soft reset");

   // register writes and phase order tracking
   a_mask_write: assert property (@(posedge clk) disable iff (!arst_n)
      (cur_ff.ph_write && cur_ff.ph_addr == irq_flags_pkg::OFS_MASK && !cur_ff.busy)
      |=> (cur_ff.mask == $past(hwdata[19:0]))) // R15
      else $error("mask write lost");
   a_select_write: assert property (@(posedge clk) disable iff (!arst_n)
      (cur_ff.ph_write && cur_ff.ph_addr == irq_flags_pkg::OFS_CALC_MODE && !cur_ff.busy)
      |=> (phase_include_select == $past(hwdata[2:0]))) // R11 R12
      else $error("phase select write lost");
   a_order_track: assert property (@(posedge clk) disable iff (!arst_n)
      (zx_rise_evt == 3'h1 && !cur_ff.busy) |=> (cur_ff.zx_last == 2'h1)) // R13
      else $error("phase a crossing not remembered");
   a_bus_okay: assert property (@(posedge clk) disable iff (!arst_n)
      (hreadyout && !hresp))
      else $error("bus answer not ready and okay");
endmodule // meter_interrupt_status_flags
`default_nettype wire

// ---- dv/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // clock and answer from the slave
   input wire logic clk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // ahb-lite request
   output logic hsel,
   output logic [7:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [31:0] hwdata
);
   logic [31:0] rd_s;
   logic rdy_s;
   // sampled before the edge, so the answer is what stood at that edge
   always @(negedge clk) begin
      rd_s = hrdata;
      rdy_s = hready;
   end
   initial begin
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge clk);
      while (rdy_s !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (rdy_s !== 1'b1) @(posedge clk);
      rd = rd_s;
   endtask
endmodule // host_model
`default_nettype wire

// ---- dv/tb_meter_interrupt_status_flags.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_meter_interrupt_status_flags;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic hsel, hwrite, hreadyout, irq_n, busy;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [31:0] hwdata, hrdata, rd;
   logic [19:0] evs = 20'h00000;
   logic [2:0] act = 3'h0, rea = 3'h0, sel;
   int err_total = 0, samples_checked = 0;
   always #2 clk = ~clk;
   host_model host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));
   meter_interrupt_status_flags #(.SOFT_RESET_CYCLES(20)) uut (.clk(clk), .arst_n(arst_n),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
      .sag_evt(evs[5:3]), .zx_timeout_evt(evs[8:6]), .zx_rise_evt(evs[11:9]),
      .line_cycle_evt(evs[12]), .volt_peak_evt(evs[14]), .curr_peak_evt(evs[15]),
      .wave_sample_evt(evs[16]), .active_sign_evt(act), .reactive_sign_evt(rea),
      .irq_n(irq_n), .soft_reset_busy(busy), .phase_include_select(sel));
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic report_and_stop();
      if (err_total == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      host.xfer(1'b0, a, 32'h0, rd);
      chk("register", rd, exp);
   endtask
   // status bits that one event step should leave set
   function automatic logic [31:0] exp_of(int k);
      // a crossing of b right after one of a is also an order error
      if (k == 10) return 32'h80400;
      return (k == 19) ? 32'h80600 : 32'h1 << k;
   endfunction
   initial begin
      logic [31:0] m;
      int n;
      void'($urandom(32'h53A73BC7));
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rdchk(8'h04, 32'h02000);
      rdchk(8'h00, 32'h0);
      rdchk(8'h20, 32'h0);
      rdchk(8'h08, 32'h02000);
      rdchk(8'h04, 32'h0);
      for (int k = 3; k < 20; k++) begin
         if (k == 13) continue;
         m = $urandom & 32'hFFFF8;
         host.xfer(1'b1, 8'h00, m, rd);
         if (k == 17) act <= 3'h1 << ($urandom % 3);
         else if (k == 18) rea <= 3'h1 << ($urandom % 3);
         else if (k == 19) evs[9] <= 1'b1;
         else evs[k] <= 1'b1;
         @(posedge clk);
         evs <= (k == 19) ? 20'h00400 : 20'h00000;
         act <= 3'h0;
         rea <= 3'h0;
         @(posedge clk);
         evs <= 20'h00000;
         @(negedge clk);
         chk("irq_n", irq_n, ~|(m[19:0] & exp_of(k)));
         @(posedge clk);
         rdchk(8'h04, exp_of(k));
         rdchk(8'h04, exp_of(k));
         rdchk(8'h08, exp_of(k));
         @(negedge clk);
         chk("irq_n", irq_n, 1'b1);
         @(posedge clk);
         rdchk(8'h04, 32'h0);
      end
      host.xfer(1'b1, 8'h00, 32'hFFFFF, rd);
      host.xfer(1'b1, 8'h10, 32'h0, rd);
      rdchk(8'h10, 32'h0);
      host.xfer(1'b1, 8'h0C, 32'h40, rd);
      n = 0;
      @(negedge clk);
      while (busy === 1'b1 && n < 100) begin
         n++;
         @(negedge clk);
      end
      chk("busy", n, 20);
      chk("irq_n", irq_n, 1'b1);
      chk("select", sel, 3'h7);
      @(posedge clk);
      rdchk(8'h04, 32'h02000);
      rdchk(8'h00, 32'h0);
      rdchk(8'h0C, 32'h0);
      report_and_stop();
   end
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      report_and_stop();
   end
endmodule // tb_meter_interrupt_status_flags
`default_nettype wire
